// >>> hw/spgcb_pkg.sv
/*
 * spgcb_pkg: offsets, field positions, reset values, codes and timing
 * for the switch / pulse / aux-pin configuration bank.
 * Assumes a byte-wide register file behind a 32-bit Avalon-MM slave.
 */
package spgcb_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SW_SRC_B   = 8'h15;
    localparam logic [7:0] IDX_IO_PIN_FN  = 8'h17;
    localparam logic [7:0] IDX_PULSE_A    = 8'h18;
    localparam logic [7:0] IDX_PULSE_B    = 8'h19;
    localparam logic [7:0] IDX_PULSE_FREQ = 8'h1c;
    localparam logic [7:0] IDX_SCRATCH    = 8'h1e;
    localparam logic [7:0] IDX_BANK_STAT  = 8'h1f;

    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] MASK_SW_SRC    = 8'h77;
    localparam logic [7:0] MASK_FREQ      = 8'h05;

    localparam int SW3_LSB   = 0;
    localparam int SW4_LSB   = 4;
    localparam int PIN1_LSB  = 0;
    localparam int PIN2_LSB  = 3;
    localparam int FODC_LSB  = 6;
    localparam int FREQA_BIT = 0;
    localparam int FREQB_BIT = 2;

    typedef enum logic [2:0] {
        SPGCB_SRC_OFF  = 3'h0,
        SPGCB_SRC_ON   = 3'h1,
        SPGCB_SRC_TMRA = 3'h2,
        SPGCB_SRC_TMRB = 3'h3,
        SPGCB_SRC_PWMA = 3'h4,
        SPGCB_SRC_PWMB = 3'h5
    } spgcb_src_t;

    typedef enum logic [2:0] {
        SPGCB_PIN_OFF  = 3'h4,
        SPGCB_PIN_WAKE = 3'h5,
        SPGCB_PIN_LS   = 3'h6,
        SPGCB_PIN_HS   = 3'h7
    } spgcb_pin_t;

    // chip operating modes seen by the bank
    typedef enum logic [1:0] {
        SPGCB_MODE_NORMAL   = 2'h0,
        SPGCB_MODE_RESTART  = 2'h1,
        SPGCB_MODE_FAILSAFE = 2'h3,
        SPGCB_MODE_OTHER    = 2'h2
    } spgcb_mode_t;

    localparam int CLK_HZ         = 50_000_000;
    localparam int PWM_STEPS      = 255;
    localparam int FREQ_LO_HZ     = 200;
    localparam int FREQ_HI_HZ     = 400;
    localparam int WAKE_FILT_US   = 16;
    localparam int WAKE_FILT_CYC  = (WAKE_FILT_US * (CLK_HZ / 1_000_000));
    localparam int TICK_LO_CYC    = CLK_HZ / (FREQ_LO_HZ * PWM_STEPS);
    localparam int TICK_HI_CYC    = CLK_HZ / (FREQ_HI_HZ * PWM_STEPS);
endpackage : spgcb_pkg

// >>> hw/spgcb_pwm.sv
/*
 * spgcb_pwm: one pulse channel, 255 steps per period, selectable rate.
 * Assumes duty and rate are stable register outputs of the bank.
 */
module spgcb_pwm #(
    parameter int TICK_LO = spgcb_pkg::TICK_LO_CYC,
    parameter int TICK_HI = spgcb_pkg::TICK_HI_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    // setting
    input  wire logic [7:0] duty_i,
    input  wire logic       rate_hi_i,
    // output
    output logic            pwm_o
);
    // prescaler must tick and fit its 16-bit counter
    if (TICK_HI < 1 || TICK_LO < TICK_HI || TICK_LO > 65535) begin : g_bad_tick
        $error("spgcb_pwm: bad tick parameters");
    end

    logic [15:0] pre_reg;
    logic [7:0]  step_reg;
    logic [15:0] pre_top;
    logic        tick;
    assign pre_top = rate_hi_i ? 16'(TICK_HI - 1) : 16'(TICK_LO - 1);
    assign tick    = (pre_reg >= pre_top);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_reg  <= 16'h0000;
            step_reg <= 8'h00;
            pwm_o    <= 1'b0;
        end else begin
            pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
            if (tick) begin
                // counts 0..254, then wraps
                step_reg <= (step_reg == 8'hfe) ? 8'h00 : step_reg + 8'h01;      // RQ16
            end
            pwm_o <= (step_reg < duty_i);                                       // RQ7
        end
    end

    pwm_full_on_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
        $stable(duty_i) && duty_i == 8'hff |=> pwm_o) else $error("duty 255 not on");
    pwm_full_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
        $stable(duty_i) && duty_i == 8'h00 |=> !pwm_o) else $error("duty 0 not off");
    pwm_step_range_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ16
        step_reg < 8'hff) else $error("step counter out of range");
endmodule // spgcb_pwm

// >>> hw/spgcb_bank.sv
/*
 * spgcb_bank: switch source, aux pin, pulse and scratch configuration bank
 * with a 32-bit Avalon-MM slave and two pulse channels.
 * Assumes the mode controller gives power-on as reset_n_i, soft reset and
 * restart entry as one-cycle pulses, and protection faults as pulses.
 */
// The implementer's own choice: register access over Avalon-MM.
//
// Behaviour
// RQ1: switch source codes select off, on, timer, pulse
// RQ2: overcurrent or overtemperature clears that switch source
// RQ3: reserved bits ignore writes and read zero
// RQ4: fail output three duty from two-bit field
// RQ5: aux pin three-bit function field decoded
// RQ6: software assigns timer when filter chosen
// RQ7: pulse duty zero off, full on, N/255
// RQ8: frequency bits select 200 or 400 Hz
// RQ9: restart keeps only the two frequency bits
// RQ10: switch source register zeroed on all resets
// RQ11: pin and duty cleared, kept through restart
// RQ12: scratch cleared at power-on only
// RQ13: device logic never alters scratch byte
// RQ14: scratch accessible only in normal mode
// RQ15: timer runs once assigned and on-time set
// RQ16: pulse uses 255-step counter, output below duty
module spgcb_bank (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    // chip mode and events
    input  wire logic [1:0]  chip_mode_i,
    input  wire logic        soft_reset_i,
    input  wire logic        restart_entry_i,
    input  wire logic [1:0]  switch_fault_i,
    // timer status
    input  wire logic        switch_timer_a_i,
    input  wire logic        switch_timer_b_i,
    input  wire logic        switch_timer_a_set_i,
    input  wire logic        switch_timer_b_set_i,
    // switch and pin controls
    output logic [1:0]       switch_on_o,
    output logic [1:0]       timer_run_o,
    output logic [1:0]       fail_output_duty_o,
    output logic [2:0]       aux_pin_one_function_o,
    output logic [2:0]       aux_pin_two_function_o,
    output logic [1:0]       aux_wake_en_o,
    output logic [1:0]       aux_ls_on_o,
    output logic [1:0]       aux_hs_on_o,
    output logic [1:0]       aux_fail_out_o,
    output logic [1:0]       pulse_o
);
    logic [7:0] sw_src_reg, sw_src_next;
    logic [7:0] pin_fn_reg, pin_fn_next;
    logic [7:0] duty_a_reg, duty_a_next;
    logic [7:0] duty_b_reg, duty_b_next;
    logic [7:0] freq_reg, freq_next;
    logic [7:0] scratch_reg, scratch_next;
    logic [31:0] rdata_reg;
    logic        ack_reg;
    logic [1:0]  resp_reg;

    // single wait state: request accepted in first cycle, answered in second
    wire req      = avs_read_i | avs_write_i;
    wire [7:0] idx = avs_address_i >> 2;
    wire aligned  = (avs_address_i[1:0] == 2'b00);
    wire lane0    = avs_byteenable_i[0];
    wire normal   = (chip_mode_i == spgcb_pkg::SPGCB_MODE_NORMAL);
    wire [7:0] wb = avs_writedata_i[7:0];
    wire hit_sw   = aligned && idx == spgcb_pkg::IDX_SW_SRC_B;
    wire hit_pin  = aligned && idx == spgcb_pkg::IDX_IO_PIN_FN;
    wire hit_da   = aligned && idx == spgcb_pkg::IDX_PULSE_A;
    wire hit_db   = aligned && idx == spgcb_pkg::IDX_PULSE_B;
    wire hit_fr   = aligned && idx == spgcb_pkg::IDX_PULSE_FREQ;
    wire hit_sc   = aligned && idx == spgcb_pkg::IDX_SCRATCH;
    wire hit_st   = aligned && idx == spgcb_pkg::IDX_BANK_STAT;
    wire sc_ok    = hit_sc && normal;                                          // RQ14
    wire mapped   = hit_sw | hit_pin | hit_da | hit_db | hit_fr | hit_st | sc_ok;
    // write lands on the completing edge, as the master sees it
    wire wr_go    = avs_write_i && ack_reg && lane0;
    wire rd_go    = avs_read_i && !ack_reg;

    wire [7:0] stat_val = {4'h0, switch_on_o, pulse_o};

    wire [7:0] rd_mux =
        hit_sw  ? sw_src_reg :
        hit_pin ? pin_fn_reg :
        hit_da  ? duty_a_reg :
        hit_db  ? duty_b_reg :
        hit_fr  ? freq_reg   :
        sc_ok   ? scratch_reg :                                                // RQ14
        hit_st  ? stat_val   : 8'h00;

    // soft reset and restart apply here; write in the same cycle loses
    wire sw_clr_all = soft_reset_i | restart_entry_i;                          // RQ10
    wire keep_clr   = soft_reset_i;                                            // RQ11

    // write merge, then hardware clears which override the write
    logic [7:0] sw_wr;
    assign sw_wr = (wr_go && hit_sw) ? (wb & spgcb_pkg::MASK_SW_SRC) : sw_src_reg; // RQ3
    always_comb begin
        sw_src_next = sw_wr;
        if (switch_fault_i[0]) begin
            sw_src_next[spgcb_pkg::SW3_LSB +: 3] = 3'h0;                       // RQ2
        end
        if (switch_fault_i[1]) begin
            sw_src_next[spgcb_pkg::SW4_LSB +: 3] = 3'h0;                       // RQ2
        end
        if (sw_clr_all) begin
            sw_src_next = spgcb_pkg::RST_ZERO;                                 // RQ10
        end
    end

    assign pin_fn_next = keep_clr ? spgcb_pkg::RST_ZERO :
                         (wr_go && hit_pin) ? wb : pin_fn_reg;                 // RQ11
    assign duty_a_next = keep_clr ? spgcb_pkg::RST_ZERO :
                         (wr_go && hit_da) ? wb : duty_a_reg;                  // RQ11
    assign duty_b_next = keep_clr ? spgcb_pkg::RST_ZERO :
                         (wr_go && hit_db) ? wb : duty_b_reg;                  // RQ11
    // restart keeps the two rate bits; others are reserved and already zero
    assign freq_next   = keep_clr ? spgcb_pkg::RST_ZERO :
                         restart_entry_i ? (freq_reg & spgcb_pkg::MASK_FREQ) : // RQ9
                         (wr_go && hit_fr) ? (wb & spgcb_pkg::MASK_FREQ) :     // RQ3
                         freq_reg;
    // only software writes in normal mode change the scratch byte
    assign scratch_next = (wr_go && sc_ok) ? wb : scratch_reg;                 // RQ13

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sw_src_reg  <= spgcb_pkg::RST_ZERO;                                // RQ10
            pin_fn_reg  <= spgcb_pkg::RST_ZERO;
            duty_a_reg  <= spgcb_pkg::RST_ZERO;
            duty_b_reg  <= spgcb_pkg::RST_ZERO;
            freq_reg    <= spgcb_pkg::RST_ZERO;
            scratch_reg <= spgcb_pkg::RST_ZERO;                                // RQ12
        end else begin
            sw_src_reg  <= sw_src_next;
            pin_fn_reg  <= pin_fn_next;
            duty_a_reg  <= duty_a_next;
            duty_b_reg  <= duty_b_next;
            freq_reg    <= freq_next;
            scratch_reg <= scratch_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= 2'b00;
        end else begin
            ack_reg  <= req && !ack_reg;
            resp_reg <= (req && !ack_reg && !mapped) ? 2'b10 : 2'b00;
            if (rd_go) begin
                rdata_reg <= {24'h00_0000, rd_mux};                            // RQ3
            end
        end
    end

    assign avs_waitrequest_o = req && !ack_reg;
    assign avs_readdata_o    = rdata_reg;
    assign avs_response_o    = resp_reg;

    // switch source decode
    logic [1:0] pwm_out;
    logic [2:0] src [2];
    assign src[0] = sw_src_reg[spgcb_pkg::SW3_LSB +: 3];
    assign src[1] = sw_src_reg[spgcb_pkg::SW4_LSB +: 3];
    assign pulse_o = pwm_out;

    logic [1:0] timer_used;
    for (genvar s = 0; s < 2; s++) begin : g_switch
        always_comb begin
            case (src[s])                                                      // RQ1
                spgcb_pkg::SPGCB_SRC_OFF:  switch_on_o[s] = 1'b0;
                spgcb_pkg::SPGCB_SRC_ON:   switch_on_o[s] = 1'b1;
                spgcb_pkg::SPGCB_SRC_TMRA: switch_on_o[s] = switch_timer_a_i;
                spgcb_pkg::SPGCB_SRC_TMRB: switch_on_o[s] = switch_timer_b_i;
                spgcb_pkg::SPGCB_SRC_PWMA: switch_on_o[s] = pwm_out[0];
                spgcb_pkg::SPGCB_SRC_PWMB: switch_on_o[s] = pwm_out[1];
                default:                   switch_on_o[s] = 1'b0;
            endcase
        end
        assign timer_used[s] = (src[0] == 3'(spgcb_pkg::SPGCB_SRC_TMRA + s)) ||
                               (src[1] == 3'(spgcb_pkg::SPGCB_SRC_TMRA + s));
    end
    // timer starts once assigned and given a running on-time
    assign timer_run_o[0] = timer_used[0] && switch_timer_a_set_i;             // RQ15
    assign timer_run_o[1] = timer_used[1] && switch_timer_b_set_i;             // RQ15

    // aux pin decode
    assign fail_output_duty_o     = pin_fn_reg[spgcb_pkg::FODC_LSB +: 2];      // RQ4
    assign aux_pin_one_function_o = pin_fn_reg[spgcb_pkg::PIN1_LSB +: 3];
    assign aux_pin_two_function_o = pin_fn_reg[spgcb_pkg::PIN2_LSB +: 3];
    logic [2:0] pin_fn [2];
    assign pin_fn[0] = aux_pin_one_function_o;
    assign pin_fn[1] = aux_pin_two_function_o;
    for (genvar p = 0; p < 2; p++) begin : g_pin
        assign aux_fail_out_o[p] = !pin_fn[p][2];                              // RQ5
        assign aux_wake_en_o[p]  = (pin_fn[p] == spgcb_pkg::SPGCB_PIN_WAKE);   // RQ5
        assign aux_ls_on_o[p]    = (pin_fn[p] == spgcb_pkg::SPGCB_PIN_LS);     // RQ5
        assign aux_hs_on_o[p]    = (pin_fn[p] == spgcb_pkg::SPGCB_PIN_HS);     // RQ5
    end

    spgcb_pwm u_pwm_a (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .duty_i    (duty_a_reg),                                               // RQ7
        .rate_hi_i (freq_reg[spgcb_pkg::FREQA_BIT]),                           // RQ8
        .pwm_o     (pwm_out[0])
    );
    spgcb_pwm u_pwm_b (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .duty_i    (duty_b_reg),                                               // RQ7
        .rate_hi_i (freq_reg[spgcb_pkg::FREQB_BIT]),                           // RQ8
        .pwm_o     (pwm_out[1])
    );

    sequence s_restart;
        restart_entry_i && !soft_reset_i;
    endsequence
    // a scratch access: request edge, then answer edge
    sequence s_scr_read;
        avs_read_i && sc_ok && !ack_reg;
    endsequence
    sequence s_scr_write;
        avs_write_i && sc_ok && ack_reg && lane0;
    endsequence

    sw_reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
        sw_src_reg[7] == 1'b0 && sw_src_reg[3] == 1'b0) else $error("reserved set");
    freq_reserved_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
        (freq_reg & ~spgcb_pkg::MASK_FREQ) == 8'h00) else $error("freq reserved set");
    fault_clear_sw_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ2
        switch_fault_i[0] |=> sw_src_reg[2:0] == 3'h0) else $error("fault not cleared");
    restart_sw_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ10
        restart_entry_i |=> sw_src_reg == 8'h00) else $error("switch src kept");
    restart_keep_freq_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ9
        s_restart |=> freq_reg == $past(freq_reg)) else $error("rate bits lost");
    restart_keep_duty_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ11
        s_restart ##0 !avs_write_i |=> duty_a_reg == $past(duty_a_reg) &&
        pin_fn_reg == $past(pin_fn_reg)) else $error("duty lost on restart");
    soft_clear_duty_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ11
        soft_reset_i |=> duty_b_reg == 8'h00 && pin_fn_reg == 8'h00) else $error("not cleared");
    scratch_stable_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ13
        !(avs_write_i && normal) |=> $stable(scratch_reg)) else $error("scratch altered");
    scratch_soft_keep_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ12
        soft_reset_i && !avs_write_i |=> $stable(scratch_reg)) else $error("scratch cleared");
    scratch_gate_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ14
        avs_read_i && hit_sc && !normal && !ack_reg |=> avs_readdata_o == 32'h0000_0000
        && avs_response_o == 2'b10) else $error("scratch read outside normal");
    src_on_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
        src[0] == 3'h1 |-> switch_on_o[0]) else $error("on code not on");
    pin_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
        pin_fn[1] == 3'h4 |-> !(aux_fail_out_o[1] | aux_wake_en_o[1] | aux_ls_on_o[1]
        | aux_hs_on_o[1])) else $error("off pin active");
    timer_run_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ15
        src[1] == 3'h3 && switch_timer_b_set_i |-> timer_run_o[1]) else $error("timer idle");

    // further checks: fault and reset clears, code decodes, timer gating, bus accesses
    fault_clear_sw4_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ2
        switch_fault_i[1] |=> sw_src_reg[6:4] == 3'h0) else $error("sw4 not cleared");
    soft_clear_sw_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ10
        soft_reset_i |=> sw_src_reg == 8'h00) else $error("soft reset kept src");
    src_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
        src[1] == 3'h0 || src[1][2:1] == 2'b11 |-> !switch_on_o[1]) else $error("off code on");
    src_timer_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
        src[0] == 3'h2 |-> switch_on_o[0] == switch_timer_a_i) else $error("timer not followed");
    src_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
        src[1] == 3'h5 |-> switch_on_o[1] == pulse_o[1]) else $error("pulse not followed");
    pin_wake_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
        pin_fn[0] == 3'h5 |-> aux_wake_en_o[0] && !aux_fail_out_o[0]) else $error("wake code");
    pin_fail_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
        pin_fn[0] < 3'h4 |-> aux_fail_out_o[0] && !aux_hs_on_o[0]) else $error("fail code");
    pin_ls_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
        pin_fn[1] == 3'h6 |-> aux_ls_on_o[1] && !aux_wake_en_o[1]) else $error("ls code");
    pin_hs_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
        pin_fn[1] == 3'h7 |-> aux_hs_on_o[1] && !aux_ls_on_o[1]) else $error("hs code");
    timer_idle_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ15
        src[0] != 3'h2 && src[1] != 3'h2 |-> !timer_run_o[0]) else $error("timer a runs");
    timer_gate_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ15
        !switch_timer_a_set_i |-> !timer_run_o[0]) else $error("timer a ungated");
    read_upper_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
        avs_readdata_o[31:8] == 24'h00_0000) else $error("upper read bits set");
    scratch_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ14
        s_scr_read |=> avs_readdata_o == {24'h00_0000, $past(scratch_reg)} &&
        avs_response_o == 2'b00) else $error("scratch read lost");
    scratch_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ14
        s_scr_write |=> scratch_reg == $past(wb)) else $error("scratch write lost");
    duty_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
        avs_write_i && ack_reg && hit_da && lane0 && !soft_reset_i
        |=> duty_a_reg == $past(wb)) else $error("duty write lost");
endmodule // spgcb_bank

// >>> dv/switch_pwm_gpio_config_bank_bench.sv
/*
 * switch_pwm_gpio_config_bank_bench: self-checking bench for spgcb_bank.
 * Assumes the bank answers each Avalon-MM access after one wait state
 * and that byte addresses are four times the register index.
 */
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module switch_pwm_gpio_config_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] A_SW   = spgcb_pkg::IDX_SW_SRC_B << 2;
    localparam logic [7:0] A_PIN  = spgcb_pkg::IDX_IO_PIN_FN << 2;
    localparam logic [7:0] A_DA   = spgcb_pkg::IDX_PULSE_A << 2;
    localparam logic [7:0] A_DB   = spgcb_pkg::IDX_PULSE_B << 2;
    localparam logic [7:0] A_FREQ = spgcb_pkg::IDX_PULSE_FREQ << 2;
    localparam logic [7:0] A_SCR  = spgcb_pkg::IDX_SCRATCH << 2;
    localparam logic [5:0] ON_TAB = 6'h16;

    logic        sys_clk_i;
    logic        reset_n_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [1:0]  avs_response_o;
    logic [1:0]  chip_mode_i;
    logic        soft_reset_i;
    logic        restart_entry_i;
    logic [1:0]  switch_fault_i;
    logic        switch_timer_a_i;
    logic        switch_timer_b_i;
    logic        switch_timer_a_set_i;
    logic        switch_timer_b_set_i;
    logic [1:0]  switch_on_o;
    logic [1:0]  timer_run_o;
    logic [1:0]  fail_output_duty_o;
    logic [2:0]  aux_pin_one_function_o;
    logic [2:0]  aux_pin_two_function_o;
    logic [1:0]  aux_wake_en_o;
    logic [1:0]  aux_ls_on_o;
    logic [1:0]  aux_hs_on_o;
    logic [1:0]  aux_fail_out_o;
    logic [1:0]  pulse_o;
    int          fails;
    int          n_tests;
    logic [2:0]  c;
    logic        e;

    spgcb_bank dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .chip_mode_i(chip_mode_i), .soft_reset_i(soft_reset_i),
        .restart_entry_i(restart_entry_i), .switch_fault_i(switch_fault_i),
        .switch_timer_a_i(switch_timer_a_i), .switch_timer_b_i(switch_timer_b_i),
        .switch_timer_a_set_i(switch_timer_a_set_i),
        .switch_timer_b_set_i(switch_timer_b_set_i),
        .switch_on_o(switch_on_o), .timer_run_o(timer_run_o),
        .fail_output_duty_o(fail_output_duty_o),
        .aux_pin_one_function_o(aux_pin_one_function_o),
        .aux_pin_two_function_o(aux_pin_two_function_o),
        .aux_wake_en_o(aux_wake_en_o), .aux_ls_on_o(aux_ls_on_o),
        .aux_hs_on_o(aux_hs_on_o), .aux_fail_out_o(aux_fail_out_o), .pulse_o(pulse_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one access; values are taken at the edge that sees waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i    <= a;
        avs_write_i      <= wr;
        avs_read_i       <= !wr;
        avs_writedata_i  <= {24'h00_0000, d};
        avs_byteenable_i <= be;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 20) begin
            @(posedge sys_clk_i);
            n++;
        end
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 20) begin
            fails++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b1, a, d, 4'hF, q, r);
        `CHK(r, er)
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b0, a, 8'h00, 4'hF, q, r);
        `CHK(q, {24'h00_0000, x})
        `CHK(r, er)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic wait_pulse(input logic [1:0] x);
        int n;
        for (n = 0; n < 1000 && pulse_o !== x; n++) @(posedge sys_clk_i);
        `CHK(pulse_o, x)
        if (n >= 1000) conclude();
    endtask

    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        fails = 0;
        n_tests = 0;
        {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hF;
        chip_mode_i = spgcb_pkg::SPGCB_MODE_NORMAL;
        {soft_reset_i, restart_entry_i, switch_fault_i} = '0;
        {switch_timer_a_i, switch_timer_b_i} = 2'h2;
        {switch_timer_a_set_i, switch_timer_b_set_i} = 2'h3;
        reset_n_i = 1'b0;
        tick(6);
        reset_n_i <= 1'b1;
        rd(A_SW, 8'h00, 2'h0);
        rd(A_PIN, 8'h00, 2'h0);
        rd(A_DA, 8'h00, 2'h0);
        rd(A_DB, 8'h00, 2'h0);
        rd(A_FREQ, 8'h00, 2'h0);
        rd(A_SCR, 8'h00, 2'h0);
        rd(8'h58, 8'h00, 2'h2);
        `CHK(pulse_o, 2'h0)
        wr(A_SW, 8'hFF, 2'h0);
        rd(A_SW, 8'h77, 2'h0);
        wr(A_FREQ, 8'hFF, 2'h0);
        rd(A_FREQ, 8'h05, 2'h0);
        wr(A_FREQ, 8'h04, 2'h0);
        rd(A_FREQ, 8'h04, 2'h0);
        // refused write: low byte lane not enabled
        xfer(1'b1, A_DB, 8'h5A, 4'hE, q, r);
        rd(A_DB, 8'h00, 2'h0);
        wr(A_DA, 8'hFF, 2'h0);
        wait_pulse(2'h1);
        for (int i = 0; i < 6; i++) begin
            c = i[2:0];
            e = ON_TAB[i];
            wr(A_SW, {1'b0, c, 1'b0, c}, 2'h0);
            tick(1);
            `CHK(switch_on_o, {e, e})
            `CHK(timer_run_o, {c == 3'h3, c == 3'h2})
        end
        wr(A_SW, 8'h22, 2'h0);
        switch_timer_a_set_i <= 1'b0;
        tick(2);
        `CHK(timer_run_o, 2'h0)
        wr(A_SW, 8'h21, 2'h0);
        switch_fault_i <= 2'h1;
        tick(1);
        switch_fault_i <= 2'h0;
        rd(A_SW, 8'h20, 2'h0);
        switch_fault_i <= 2'h2;
        tick(1);
        switch_fault_i <= 2'h0;
        rd(A_SW, 8'h00, 2'h0);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(A_PIN, {c[1:0], c, c}, 2'h0);
            tick(1);
            `CHK(fail_output_duty_o, c[1:0])
            `CHK({aux_pin_two_function_o, aux_pin_one_function_o}, {c, c})
            `CHK(aux_fail_out_o, {2{c < 3'h4}})
            `CHK({aux_wake_en_o, aux_ls_on_o, aux_hs_on_o},
                 {{2{c == 3'h5}}, {2{c == 3'h6}}, {2{c == 3'h7}}})
        end
        // every register loaded, then restart entry while out of normal mode
        wr(A_SW, 8'h55, 2'h0);
        wr(A_PIN, 8'hA5, 2'h0);
        wr(A_DA, 8'h3C, 2'h0);
        wr(A_DB, 8'hC3, 2'h0);
        wr(A_FREQ, 8'h05, 2'h0);
        wr(A_SCR, 8'h9E, 2'h0);
        chip_mode_i <= spgcb_pkg::SPGCB_MODE_RESTART;
        restart_entry_i <= 1'b1;
        tick(1);
        restart_entry_i <= 1'b0;
        rd(A_SCR, 8'h00, 2'h2);
        wr(A_SCR, 8'h11, 2'h2);
        chip_mode_i <= spgcb_pkg::SPGCB_MODE_FAILSAFE;
        tick(4);
        chip_mode_i <= spgcb_pkg::SPGCB_MODE_NORMAL;
        rd(A_SW, 8'h00, 2'h0);
        rd(A_PIN, 8'hA5, 2'h0);
        rd(A_DA, 8'h3C, 2'h0);
        rd(A_DB, 8'hC3, 2'h0);
        rd(A_FREQ, 8'h05, 2'h0);
        rd(A_SCR, 8'h9E, 2'h0);
        wr(A_SW, 8'h11, 2'h0);
        soft_reset_i <= 1'b1;
        tick(1);
        soft_reset_i <= 1'b0;
        rd(A_SW, 8'h00, 2'h0);
        rd(A_PIN, 8'h00, 2'h0);
        rd(A_DA, 8'h00, 2'h0);
        rd(A_DB, 8'h00, 2'h0);
        rd(A_SCR, 8'h9E, 2'h0);
        tick(1);
        reset_n_i <= 1'b0;
        tick(2);
        reset_n_i <= 1'b1;
        rd(A_SCR, 8'h00, 2'h0);
        conclude();
    end
endmodule // switch_pwm_gpio_config_bank_bench
